// >>> hw/adcrs_top.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module adcrs_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Converter core
	input  wire logic        conv_done,
	input  wire logic [9:0]  conv_result,
	output logic             conv_start_q,
	output logic [1:0]       conv_channel_q,
	output logic [4:0]       chan_select_q,
	output logic             conv_irq_q
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a == {2'b00, idx, 2'b00});
	endfunction

	logic wr_en;
	logic rd_en;
	logic setup;
	assign setup = psel && !penable;
	assign wr_en = setup && pwrite;
	assign rd_en = setup && !pwrite;

	logic wr_sc;
	logic wr_ck;
	logic wr_scan;
	logic rd_high;
	logic rd_low;
	logic rd_any_low;
	assign wr_sc      = wr_en && hit(paddr, adcrs_pkg::IDX_STATUS_CONTROL);
	assign wr_ck      = wr_en && hit(paddr, adcrs_pkg::IDX_CLOCK_CONTROL);
	assign wr_scan    = wr_en && hit(paddr, adcrs_pkg::IDX_SCAN_CONTROL);
	assign rd_high    = rd_en && hit(paddr, adcrs_pkg::IDX_RESULT_HIGH);
	assign rd_low     = rd_en && hit(paddr, adcrs_pkg::IDX_RESULT_LOW);
	assign rd_any_low = rd_low || (rd_en && (hit(paddr, adcrs_pkg::IDX_SCAN_CH1)
		|| hit(paddr, adcrs_pkg::IDX_SCAN_CH2) || hit(paddr, adcrs_pkg::IDX_SCAN_CH3)));

	logic mapped;
	always_comb
	begin
		mapped = 1'b0;
		for (int i = 32'h57; i <= 32'h5E; i++)
			if (hit(paddr, 8'(i)))
				mapped = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	logic [4:0] chan_sel_q;
	logic       irq_en_q;
	logic       cont_q;
	logic [1:0] mode_q;
	logic [4:0] clk_div_q;
	logic       scan_en_q;
	logic [1:0] scan_len_q;
	logic       start_req;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_sel_q <= 5'h1F;
			irq_en_q   <= 1'b0;
			cont_q     <= 1'b0;
		end
		else if (wr_sc)
		begin
			chan_sel_q <= pwdata[4:0];
			irq_en_q   <= pwdata[adcrs_pkg::SC_IRQEN_BIT];
			cont_q     <= pwdata[adcrs_pkg::SC_CONT_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q    <= adcrs_pkg::MODE_RESET;
			clk_div_q <= 5'h00;
		end
		else if (wr_ck)
		begin
			mode_q    <= pwdata[adcrs_pkg::CK_MODE_LSB +: 2];
			clk_div_q <= {pwdata[7:5], pwdata[4], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scan_en_q  <= 1'b0;
			scan_len_q <= adcrs_pkg::SCAN_LEN_RESET;
		end
		else if (wr_scan)
		begin
			scan_en_q  <= pwdata[adcrs_pkg::SCN_EN_BIT];
			scan_len_q <= pwdata[adcrs_pkg::SCN_LEN_LSB +: 2];
		end
	end

	// Powered-off code on the channel field stops conversions
	assign start_req = wr_sc && pwdata[4:0] != 5'h1F;

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	logic       seq_start;
	logic [1:0] seq_chan;
	logic       seq_busy;
	adcrs_sequencer u_seq (
		.clk                (clk),
		.rst_n              (rst_n),
		.start              (start_req),
		.abort              (wr_sc && !start_req),
		.scan_enable        (scan_en_q),
		.continuous_convert (cont_q),
		.scan_len           (scan_len_q),
		.conv_done          (conv_done),
		.conv_start         (seq_start),
		.conv_channel       (seq_chan),
		.busy               (seq_busy)
	);

	// Channel of the conversion in flight, tagged to its done pulse
	logic [1:0] done_chan;
	assign done_chan = seq_chan;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conv_start_q   <= 1'b0;
			conv_channel_q <= 2'b00;
			chan_select_q  <= 5'h1F;
		end
		else
		begin
			conv_start_q   <= seq_start;
			conv_channel_q <= seq_chan;
			chan_select_q  <= scan_en_q ? {3'b000, seq_chan} : chan_sel_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result formatting and interlock
	logic [7:0] fmt_high;
	logic [7:0] fmt_low;
	always_comb
	begin
		case (mode_q)
			adcrs_pkg::ADCRS_TRUNC:
			begin
				fmt_high = 8'h00;
				fmt_low  = conv_result[9:2];
			end
			adcrs_pkg::ADCRS_RIGHT:
			begin
				fmt_high = {6'h00, conv_result[9:8]};
				fmt_low  = conv_result[7:0];
			end
			adcrs_pkg::ADCRS_LEFT:
			begin
				fmt_high = conv_result[9:2];
				fmt_low  = {conv_result[1:0], 6'h00};
			end
			adcrs_pkg::ADCRS_SIGNED:
			begin
				fmt_high = {~conv_result[9], conv_result[8:2]};
				fmt_low  = {conv_result[1:0], 6'h00};
			end
			default:
			begin
				fmt_high = 8'h00;
				fmt_low  = 8'h00;
			end
		endcase
	end

	logic       trunc;
	logic       locked_q;
	logic       prim_upd;
	logic [7:0] high_q;
	logic [7:0] low_q;
	logic [7:0] scan_q [1:3];

	assign trunc    = (mode_q == adcrs_pkg::ADCRS_TRUNC);
	// Primary takes channel 0 when scanning, any done otherwise
	assign prim_upd = conv_done && (!scan_en_q || done_chan == 2'b00)
		&& (trunc || !locked_q);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			locked_q <= 1'b0;
		else if (trunc)
			locked_q <= 1'b0;
		else if (rd_high)
			locked_q <= 1'b1;
		else if (rd_low)
			locked_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			high_q <= adcrs_pkg::BYTE_RESET;
			low_q  <= adcrs_pkg::BYTE_RESET;
		end
		else if (prim_upd)
		begin
			high_q <= fmt_high;
			low_q  <= fmt_low;
		end
	end

	generate
		for (genvar g = 1; g <= 3; g++)
		begin : g_scan
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					scan_q[g] <= adcrs_pkg::BYTE_RESET;
				else if (conv_done && scan_en_q && done_chan == 2'(g))
					scan_q[g] <= conv_result[9:2];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Done flag and interrupt
	logic done_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			done_q <= 1'b0;
		else if (conv_done && !irq_en_q)
			done_q <= 1'b1;
		else if (rd_any_low || wr_sc || wr_ck || irq_en_q)
			done_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			conv_irq_q <= 1'b0;
		else if (conv_done && irq_en_q)
			conv_irq_q <= 1'b1;
		else if (rd_high || rd_low || wr_sc || !irq_en_q)
			conv_irq_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux, one cycle answer in the access phase
	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		if (hit(paddr, adcrs_pkg::IDX_STATUS_CONTROL))
			rd_byte = {done_q && !irq_en_q, irq_en_q, cont_q, chan_sel_q};
		else if (hit(paddr, adcrs_pkg::IDX_CLOCK_CONTROL))
			rd_byte = {clk_div_q[4:1], mode_q, 2'b00};
		else if (hit(paddr, adcrs_pkg::IDX_RESULT_HIGH))
			rd_byte = high_q;
		else if (hit(paddr, adcrs_pkg::IDX_RESULT_LOW))
			rd_byte = low_q;
		else if (hit(paddr, adcrs_pkg::IDX_SCAN_CH1))
			rd_byte = scan_q[1];
		else if (hit(paddr, adcrs_pkg::IDX_SCAN_CH2))
			rd_byte = scan_q[2];
		else if (hit(paddr, adcrs_pkg::IDX_SCAN_CH3))
			rd_byte = scan_q[3];
		else if (hit(paddr, adcrs_pkg::IDX_SCAN_CONTROL))
			rd_byte = {5'h00, scan_en_q, scan_len_q};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (rd_en)
				prdata <= {24'h000000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_TRUNC_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && trunc && !scan_en_q |=> low_q == $past(conv_result[9:2]))
		else $error("truncated low byte wrong");
	AST_RIGHT_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		prim_upd && mode_q == adcrs_pkg::ADCRS_RIGHT |=> high_q[7:2] == 6'h00)
		else $error("right justified high bits not zero");
	AST_LEFT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		prim_upd && mode_q[1] |=> low_q[5:0] == 6'h00 && low_q[7:6] == $past(conv_result[1:0]))
		else $error("left justified low byte wrong");
	AST_SIGN_MSB: assert property (@(posedge clk) disable iff (!rst_n)
		prim_upd && mode_q == adcrs_pkg::ADCRS_SIGNED |=> high_q[7] != $past(conv_result[9]))
		else $error("sign bit not inverted");
	AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		locked_q && !trunc && !rd_low |=> $stable(low_q))
		else $error("locked low byte changed");
	AST_LOCK_SET: assert property (@(posedge clk) disable iff (!rst_n)
		rd_high && !trunc |=> locked_q)
		else $error("high read did not lock");
	AST_TRUNC_NOLOCK: assert property (@(posedge clk) disable iff (!rst_n)
		trunc && conv_done && !scan_en_q |-> prim_upd)
		else $error("truncated update blocked");
	AST_SCAN_CH: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && scan_en_q && done_chan == 2'b10 |=> scan_q[2] == $past(conv_result[9:2]))
		else $error("scan register not written");
	AST_DONE_SET: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && !irq_en_q |=> done_q)
		else $error("done flag not set");
	AST_IRQ_SET: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && irq_en_q |=> conv_irq_q)
		else $error("interrupt not raised");
	AST_LEN_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
		scan_en_q && seq_busy |-> seq_chan <= scan_len_q)
		else $error("scan past selected length");
	AST_READY: assert property (@(posedge clk) disable iff (!rst_n)
		setup |=> pready ##1 !pready)
		else $error("bus answer timing");
	COV_LOCKED_READ: cover property (@(posedge clk) disable iff (!rst_n)
		rd_high && !trunc ##[1:20] rd_low);
	COV_SCAN_ALL: cover property (@(posedge clk) disable iff (!rst_n)
		conv_done && scan_en_q && done_chan == 2'b11);
	COV_DROPPED: cover property (@(posedge clk) disable iff (!rst_n)
		conv_done && locked_q && !trunc);

endmodule

// >>> hw/adcrs_pkg.sv
package adcrs_pkg;

	// Printed offsets are not multiples of four: kept as indices, byte address = 4 * index
	localparam logic [7:0] IDX_STATUS_CONTROL = 8'h57;
	localparam logic [7:0] IDX_CLOCK_CONTROL  = 8'h58;
	localparam logic [7:0] IDX_RESULT_HIGH    = 8'h59;
	localparam logic [7:0] IDX_RESULT_LOW     = 8'h5A;
	localparam logic [7:0] IDX_SCAN_CH1       = 8'h5B;
	localparam logic [7:0] IDX_SCAN_CH2       = 8'h5C;
	localparam logic [7:0] IDX_SCAN_CH3       = 8'h5D;
	localparam logic [7:0] IDX_SCAN_CONTROL   = 8'h5E;

	// Status/control bit positions
	localparam int SC_DONE_BIT  = 7;
	localparam int SC_IRQEN_BIT = 6;
	localparam int SC_CONT_BIT  = 5;
	// Scan control bit positions
	localparam int SCN_EN_BIT   = 2;
	localparam int SCN_LEN_LSB  = 0;
	// Clock control: justification field position
	localparam int CK_MODE_LSB  = 2;

	typedef enum logic [1:0] {
		ADCRS_TRUNC  = 2'b00,
		ADCRS_RIGHT  = 2'b01,
		ADCRS_LEFT   = 2'b10,
		ADCRS_SIGNED = 2'b11
	} adcrs_just_t;

	localparam logic [1:0] MODE_RESET     = 2'b01;
	localparam logic [1:0] SCAN_LEN_RESET = 2'b00;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam int         START_DELAY    = 1;

endpackage

// >>> hw/adcrs_sequencer.sv
`timescale 1ns/1ps
module adcrs_sequencer (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       start,
	input  wire logic       abort,
	input  wire logic       scan_enable,
	input  wire logic       continuous_convert,
	input  wire logic [1:0] scan_len,
	// Converter core
	input  wire logic       conv_done,
	output logic            conv_start,
	output logic [1:0]      conv_channel,
	output logic            busy
);

	logic       active_q;
	logic [1:0] chan_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_q   <= 1'b0;
			chan_q     <= 2'b00;
			conv_start <= 1'b0;
		end
		else if (abort)
		begin
			active_q   <= 1'b0;
			chan_q     <= 2'b00;
			conv_start <= 1'b0;
		end
		else
		begin
			conv_start <= 1'b0;
			if (start && !active_q)
			begin
				active_q   <= 1'b1;
				chan_q     <= 2'b00;
				conv_start <= 1'b1;
			end
			else if (active_q && conv_done)
			begin
				// Ascending channel walk while scanning
				if (scan_enable && chan_q != scan_len)
				begin
					chan_q     <= chan_q + 2'b01;
					conv_start <= 1'b1;
				end
				else if (continuous_convert || scan_enable)
				begin
					// A full scan pass repeats only in continuous mode
					chan_q     <= 2'b00;
					conv_start <= continuous_convert;
					active_q   <= continuous_convert;
				end
				else
					active_q <= 1'b0;
			end
		end
	end

	assign conv_channel = chan_q;
	assign busy         = active_q;

endmodule

// >>> test/adcrs_core_model.sv
`timescale 1ns/1ps
module adcrs_core_model (
	// Clock
	input  wire logic        clk,
	// Converter side of the block
	input  wire logic        conv_start_q,
	input  wire logic [1:0]  conv_channel_q,
	output logic             conv_done,
	output logic [9:0]       conv_result,
	// Bench control and log
	input  wire logic [39:0] samples,
	input  wire logic [3:0]  delay,
	output int               done_cnt,
	output logic [7:0]       ch_log
);
	logic [1:0] ch;

	initial
	begin
		conv_done = 1'b0;
		conv_result = 10'h3FF;
		done_cnt = 0;
		ch_log = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One result per start; the wait varies so prompt and slow cores are both seen
	always @(posedge clk)
		if (conv_start_q === 1'b1)
		begin
			ch = conv_channel_q;
			repeat (delay) @(posedge clk);
			conv_done <= 1'b1;
			conv_result <= samples[ch * 10 +: 10];
			done_cnt <= done_cnt + 1;
			ch_log <= {ch_log[5:0], ch};
			@(posedge clk);
			conv_done <= 1'b0;
			// Stale data must not look valid outside the done cycle
			conv_result <= ~samples[ch * 10 +: 10];
		end
endmodule

// >>> test/adcrs_top_tb_top.sv
`timescale 1ns/1ps
module adcrs_top_tb_top;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        conv_done, conv_start_q, conv_irq_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0]  conv_result, a;
	logic [1:0]  conv_channel_q;
	logic [4:0]  chan_select_q;
	logic [39:0] samples;
	logic [3:0]  delay;
	logic [7:0]  ch_log, v, c, msk;
	logic [15:0] e, f;
	logic        er;
	int          errors, checks, seed, done_cnt, t, t2;

	adcrs_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.conv_done(conv_done), .conv_result(conv_result), .conv_start_q(conv_start_q),
		.conv_channel_q(conv_channel_q), .chan_select_q(chan_select_q), .conv_irq_q(conv_irq_q));
	adcrs_core_model core (.clk(clk), .conv_start_q(conv_start_q),
		.conv_channel_q(conv_channel_q), .conv_done(conv_done), .conv_result(conv_result),
		.samples(samples), .delay(delay), .done_cnt(done_cnt), .ch_log(ch_log));

	always #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		cmpf(pready, 1'b1);
		v = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let the release land before the next setup cycle
		@(posedge clk);
	endtask

	task automatic cmpb(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t byte got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpf(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		cmpb(v, exp);
	endtask

	task automatic conv(input logic [7:0] sc, input int n);
		samples <= 40'({$random(seed), $random(seed)});
		delay <= 4'($random(seed));
		t = done_cnt + n;
		apb(1'b1, adcrs_pkg::IDX_STATUS_CONTROL, sc);
		for (int k = 0; k < 400 && done_cnt < t; k++) @(posedge clk);
		repeat (3) @(posedge clk);
		cmpf(done_cnt == t, 1'b1);
	endtask

	function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
		case (m)
			2'b00: fmt = {8'h00, r[9:2]};
			2'b01: fmt = {6'h00, r};
			2'b10: fmt = {r, 6'h00};
			default: fmt = {~r[9], r[8:0], 6'h00};
		endcase
	endfunction

	task tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#160000;
		errors++;
		tally_and_finish();
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		samples = '0;
		delay = 4'h0;
		errors = 0;
		checks = 0;
		seed = 32'h8892C545;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) rdc(8'(adcrs_pkg::IDX_RESULT_HIGH + i), 8'h00);
		cmpb({3'b000, chan_select_q}, 8'h1F);
		rdc(adcrs_pkg::IDX_SCAN_CONTROL, 8'h00);
		apb(1'b0, adcrs_pkg::IDX_CLOCK_CONTROL, 8'h00);
		cmpb(v & 8'h0C, 8'h04);
		apb(1'b0, 8'h60, 8'h00);
		cmpf(er, 1'b1);
		apb(1'b1, adcrs_pkg::IDX_RESULT_LOW, 8'hA5);
		rdc(adcrs_pkg::IDX_RESULT_LOW, 8'h00);
		// Each format: a second result arrives between high and low reads
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, adcrs_pkg::IDX_CLOCK_CONTROL, {4'h0, m[1:0], 2'b00});
			conv(8'h00, 1);
			a = samples[9:0];
			apb(1'b0, adcrs_pkg::IDX_STATUS_CONTROL, 8'h00);
			cmpb(v & 8'h80, 8'h80);
			e = fmt(m[1:0], a);
			rdc(adcrs_pkg::IDX_RESULT_HIGH, e[15:8]);
			conv(8'h00, 1);
			f = fmt(m[1:0], samples[9:0]);
			rdc(adcrs_pkg::IDX_RESULT_LOW, (m == 0) ? f[7:0] : e[7:0]);
			apb(1'b0, adcrs_pkg::IDX_STATUS_CONTROL, 8'h00);
			cmpb(v & 8'h80, 8'h00);
			conv(8'h00, 1);
			f = fmt(m[1:0], samples[9:0]);
			rdc(adcrs_pkg::IDX_RESULT_HIGH, f[15:8]);
			rdc(adcrs_pkg::IDX_RESULT_LOW, f[7:0]);
		end
		conv(8'h45, 1);
		cmpb({3'b000, chan_select_q}, 8'h05);
		cmpf(conv_irq_q, 1'b1);
		apb(1'b0, adcrs_pkg::IDX_RESULT_HIGH, 8'h00);
		cmpf(conv_irq_q, 1'b0);
		apb(1'b0, adcrs_pkg::IDX_RESULT_LOW, 8'h00);
		t = done_cnt;
		apb(1'b1, adcrs_pkg::IDX_STATUS_CONTROL, 8'h20);
		for (int k = 0; k < 300 && done_cnt < t + 3; k++) @(posedge clk);
		cmpf(done_cnt >= t + 3, 1'b1);
		apb(1'b1, adcrs_pkg::IDX_STATUS_CONTROL, 8'h1F);
		repeat (40) @(posedge clk);
		t2 = done_cnt;
		repeat (60) @(posedge clk);
		cmpf(done_cnt == t2, 1'b1);
		// Scan lengths 0 to 3, truncated format
		apb(1'b1, adcrs_pkg::IDX_CLOCK_CONTROL, 8'h00);
		for (int n = 0; n < 4; n++)
		begin
			apb(1'b1, adcrs_pkg::IDX_SCAN_CONTROL, 8'h04 | n[7:0]);
			rdc(adcrs_pkg::IDX_SCAN_CONTROL, 8'h04 | n[7:0]);
			conv(8'h00, n + 1);
			c = 8'h00;
			for (int i = 0; i <= n; i++) c = {c[5:0], i[1:0]};
			msk = 8'hFF >> (6 - 2 * n);
			cmpb(ch_log & msk, c & msk);
			rdc(adcrs_pkg::IDX_RESULT_LOW, samples[9:2]);
			for (int i = 1; i <= n; i++)
				rdc(8'(adcrs_pkg::IDX_RESULT_LOW + i), samples[10 * i + 2 +: 8]);
		end
		apb(1'b1, adcrs_pkg::IDX_SCAN_CONTROL, 8'h00);
		tally_and_finish();
	end
endmodule
